// *** hdl/host_read_port.sv ***
// Read side of the asynchronous host port with FIFO-direct mode
`timescale 1ns/100ps
`default_nettype none
module host_read_port #(
   parameter int BURST_32 = host_read_pkg::BURST_MAX_32,
   parameter int BURST_16 = host_read_pkg::BURST_MAX_16
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        chip_select_low_i,  // Host chip select
   input  wire logic        read_strobe_low_i,  // Host read strobe
   input  wire logic        fifo_sel_i,         // FIFO-direct select
   input  wire logic [7:1]  addr_i,             // Host address A[7:1]
   input  wire logic        bus16_i,            // 16-bit bus mode
   input  wire logic [31:0] rx_data_i,          // RX data FIFO head
   input  wire logic [31:0] rx_sts_i,           // RX status FIFO head
   input  wire logic [31:0] tx_sts_i,           // TX status FIFO head
   input  wire logic [31:0] rx_fifo_fill_info_i, // RX fill levels
   input  wire logic [31:0] tx_fifo_fill_info_i, // TX fill levels
   input  wire logic [31:0] rx_datapath_control_i, // Datapath control
   input  wire logic [31:0] rx_drop_i,          // Dropped frame count
   output logic [31:0]      data_o,             // Host data bus out
   output logic [31:0]      data_oe_o,          // Per-bit drive enable
   output logic             rx_data_pop_o,      // Pop RX data word
   output logic             rx_sts_pop_o,       // Pop RX status word
   output logic             tx_sts_pop_o,       // Pop TX status word
   output logic             rx_drop_clr_o,      // Clear-on-read counter
   output logic             burst_over_o        // Burst length exceeded
);
   // ----------------------------------------------------------------
   // Synchronised host levels
   // ----------------------------------------------------------------
   logic [2:0]  lvl_s;                  // {fifo_sel, rd_n, cs_n}
   logic [7:1]  addr_q;                 // Address sampled with strobes
   logic [7:1]  addr_prev_q;            // Address of last fetch
   logic        active;                 // Both strobes asserted
   host_read_pkg::rd_state_t state_q;   // Cycle state
   logic [4:0]  beat_q;                 // Beats in current burst
   host_read_pkg::pop_t pend_q;         // Pops owed at beat end

   strobe_sync #(
      .WIDTH     (3),
      .RESET_VAL (3'b011)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({fifo_sel_i, read_strobe_low_i, chip_select_low_i}),
      .sync_o  (lvl_s)
   );

   // Address is static while strobes settle; take it as synchronous
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_q <= 7'h00;
      end else begin
         addr_q <= addr_i;
      end
   end

   // Cycle runs only while both strobes are low
   assign active = ~lvl_s[0] & ~lvl_s[1];

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Effective byte address; direct mode keeps only A[2:1]
   function automatic logic [7:0] eff_addr(input logic [7:1] a,
                                           input logic       fsel);
      logic [7:0] r;
      r = {a, 1'b0};
      if (fsel) begin
         r = {5'h00, a[2:1], 1'b0};
      end
      return r;
   endfunction : eff_addr

   // Word select drops A1, which only picks the halfword
   function automatic logic [7:0] word_addr(input logic [7:0] a);
      return {a[7:2], 2'b00};
   endfunction : word_addr

   logic [7:0]  cur_addr;               // Decoded address now
   logic [31:0] rd_word;                // Selected read word
   host_read_pkg::pop_t rd_pop;         // Side effect of this word
   logic        rd_drop;                // Counter read

   assign cur_addr = eff_addr(addr_q, lvl_s[2]);

   // Select source word and its side effect
   always_comb begin
      rd_word = host_read_pkg::UNMAPPED_VALUE;
      rd_pop  = '0;
      rd_drop = 1'b0;
      if (lvl_s[2]) begin
         rd_word        = rx_data_i;
         rd_pop.rx_data = 1'b1;
      end else begin
         case (word_addr(cur_addr))
            host_read_pkg::RX_DATA_OFF: begin
               rd_word        = rx_data_i;
               rd_pop.rx_data = 1'b1;
            end
            host_read_pkg::RX_STS_OFF: begin
               rd_word       = rx_sts_i;
               rd_pop.rx_sts = 1'b1;
            end
            host_read_pkg::TX_STS_OFF: begin
               rd_word       = tx_sts_i;
               rd_pop.tx_sts = 1'b1;
            end
            host_read_pkg::PROBE_OFF:  rd_word = host_read_pkg::PROBE_VALUE;
            host_read_pkg::RX_DP_OFF:  rd_word = rx_datapath_control_i;
            host_read_pkg::RX_INF_OFF: rd_word = rx_fifo_fill_info_i;
            host_read_pkg::TX_INF_OFF: rd_word = tx_fifo_fill_info_i;
            host_read_pkg::RX_DROP_OFF: begin
               rd_word = rx_drop_i;
               rd_drop = 1'b1;
            end
            default:   rd_word = host_read_pkg::UNMAPPED_VALUE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Cycle state machine
   // ----------------------------------------------------------------
   logic fetch;                          // Latch data this cycle
   logic addr_moved;                     // Burst address changed
   logic beat_end;                       // Current beat is complete
   logic wait_q;                         // First cycle after a burst move

   assign addr_moved = (state_q == host_read_pkg::ST_HOLD) && active &&
                       (addr_q != addr_prev_q);
   // A burst move waits two cycles so the popped FIFO head has moved on
   assign fetch    = ((state_q == host_read_pkg::ST_IDLE) && active) ||
                     ((state_q == host_read_pkg::ST_FETCH) && active &&
                      !wait_q);
   assign beat_end = (state_q == host_read_pkg::ST_HOLD) &&
                     (~active || addr_moved);

   // Marks the first settle cycle of a burst move
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= addr_moved;
      end
   end

   // State advance: idle, hold while strobes low, settle on a move
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= host_read_pkg::ST_IDLE;
      end else begin
         case (state_q)
            host_read_pkg::ST_IDLE: begin
               if (active) begin
                  state_q <= host_read_pkg::ST_HOLD;
               end
            end
            host_read_pkg::ST_FETCH: begin
               if (!active) begin
                  state_q <= host_read_pkg::ST_IDLE;
               end else if (!wait_q) begin
                  state_q <= host_read_pkg::ST_HOLD;
               end
            end
            host_read_pkg::ST_HOLD: begin
               if (!active) begin
                  state_q <= host_read_pkg::ST_IDLE;
               end else if (addr_moved) begin
                  state_q <= host_read_pkg::ST_FETCH;
               end
            end
            default: state_q <= host_read_pkg::ST_IDLE;
         endcase
      end
   end

   // Data latched at beat start so counters are frozen
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         data_o      <= 32'h00000000;
         addr_prev_q <= 7'h00;
      end else if (fetch) begin
         addr_prev_q <= addr_q;
         if (bus16_i && cur_addr[1]) begin
            data_o <= {16'h0000, rd_word[31:16]};
         end else begin
            data_o <= rd_word;
         end
      end
   end

   // Drive enables follow the cycle; upper half off in 16-bit mode
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         data_oe_o <= 32'h00000000;
      end else if (active) begin
         // Stays on through burst settle cycles
         data_oe_o <= bus16_i ? 32'h0000ffff : 32'hffffffff;
      end else begin
         data_oe_o <= 32'h00000000;
      end
   end

   // Remember side effects; in 16-bit mode only the upper half pops
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_q <= '0;
      end else if (fetch) begin
         pend_q <= (bus16_i && !cur_addr[1]) ? '0 : rd_pop;
      end else if (beat_end) begin
         pend_q <= '0;
      end
   end

   // At most one pop pulse per completed read beat
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_data_pop_o <= 1'b0;
         rx_sts_pop_o  <= 1'b0;
         tx_sts_pop_o  <= 1'b0;
      end else begin
         rx_data_pop_o <= beat_end & pend_q.rx_data;
         rx_sts_pop_o  <= beat_end & pend_q.rx_sts;
         tx_sts_pop_o  <= beat_end & pend_q.tx_sts;
      end
   end

   // Counter clears once per read, at the beat's start
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_drop_clr_o <= 1'b0;
      end else begin
         rx_drop_clr_o <= fetch & rd_drop & ~lvl_s[2];
      end
   end

   // ----------------------------------------------------------------
   // Burst length watch
   // ----------------------------------------------------------------
   // Counts beats; flags a burst longer than allowed (non-direct only)
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         beat_q       <= 5'h00;
         burst_over_o <= 1'b0;
      end else if (state_q == host_read_pkg::ST_IDLE) begin
         beat_q       <= active ? 5'h01 : 5'h00;
         burst_over_o <= 1'b0;
      end else if (addr_moved) begin
         beat_q <= beat_q + 5'h01;
         if (!lvl_s[2] && ((bus16_i && beat_q >= 5'(BURST_16)) ||
             (!bus16_i && beat_q >= 5'(BURST_32)))) begin
            burst_over_o <= 1'b1;
         end
      end
   end
endmodule : host_read_port
`default_nettype wire

// *** hdl/host_read_pkg.sv ***
// Package with constants and types for the host read port
package host_read_pkg;
   // -----------------------------------------------------------------
   // Address map and widths
   // -----------------------------------------------------------------
   localparam int          ADDR_W          = 8;     // Byte address A[7:0]; pins carry A[7:1]
   localparam int          DATA_W          = 32;    // Host data bus
   localparam logic [7:0]  RX_DATA_OFF     = 8'h00; // RX data FIFO port
   localparam logic [7:0]  RX_STS_OFF      = 8'h40; // RX status FIFO
   localparam logic [7:0]  TX_STS_OFF      = 8'h48; // TX status FIFO
   localparam logic [7:0]  PROBE_OFF       = 8'h64; // Probe register
   localparam logic [7:0]  RX_DP_OFF       = 8'h78; // Datapath control
   localparam logic [7:0]  RX_INF_OFF      = 8'h7c; // RX fill info
   localparam logic [7:0]  TX_INF_OFF      = 8'h80; // TX fill info
   localparam logic [7:0]  RX_DROP_OFF     = 8'ha0; // Dropped frames
   localparam logic [31:0] PROBE_VALUE     = 32'h87654321; // Fixed probe
   localparam logic [31:0] UNMAPPED_VALUE  = 32'h00000000; // Unmapped read
   localparam int          LOW_ADDR_LSB    = 1;     // A[2:1] kept in direct
   localparam int          LOW_ADDR_MSB    = 2;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          BURST_MAX_32    = 8;     // Words per 32-bit burst
   localparam int          BURST_MAX_16    = 16;    // Halfwords per burst
   localparam int          ADDR_TO_DATA_NS = 40;    // Address to data max
   localparam int          ADDR_TO_DATA_CY =
      (ADDR_TO_DATA_NS / CLK_PERIOD_NS) < 1 ? 1 :
      ADDR_TO_DATA_NS / CLK_PERIOD_NS;            // Longest, at least one
   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,  // No cycle
      ST_FETCH = 2'b01,  // Burst move, waiting for the FIFO head
      ST_HOLD  = 2'b10   // Data driven, watching address
   } rd_state_t;

   typedef struct packed {
      logic                rx_data;   // Pop RX data FIFO
      logic                rx_sts;    // Pop RX status FIFO
      logic                tx_sts;    // Pop TX status FIFO
   } pop_t;
endpackage : host_read_pkg

// *** hdl/strobe_sync.sv ***
// Two-flop synchroniser for a group of asynchronous host levels
`timescale 1ns/100ps
`default_nettype none
module strobe_sync #(
   parameter int          WIDTH = 3,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,   // Raw host levels
   output logic      [WIDTH-1:0] sync_o     // Levels in clk_i domain
);
   // ----------------------------------------------------------------
   // Synchroniser stages
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] meta_q;                // First stage, read only below

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         // Two flops per bit
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               meta_q[g] <= RESET_VAL[g];
               sync_o[g] <= RESET_VAL[g];
            end else begin
               meta_q[g] <= async_i[g];
               sync_o[g] <= meta_q[g];
            end
         end
      end
   endgenerate
endmodule : strobe_sync
`default_nettype wire

// *** tb/host_read_port_asserts.sv ***
// Concurrent checks on the host read port pins
`timescale 1ns/100ps
`default_nettype none
module host_read_port_asserts #(
   parameter int BURST_32 = 8,
   parameter int BURST_16 = 16
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        chip_select_low_i,
   input  wire logic        read_strobe_low_i,
   input  wire logic        fifo_sel_i,
   input  wire logic [7:1]  addr_i,
   input  wire logic        bus16_i,
   input  wire logic [31:0] rx_data_i,
   input  wire logic [31:0] data_o,
   input  wire logic [31:0] data_oe_o,
   input  wire logic        rx_data_pop_o,
   input  wire logic        rx_sts_pop_o,
   input  wire logic        tx_sts_pop_o,
   input  wire logic        rx_drop_clr_o,
   input  wire logic        burst_over_o
);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic act;  // Both strobes low at the pins
   assign act = !chip_select_low_i && !read_strobe_low_i;

   AST_OE_OFF: assert property ((!act)[*3] |=> data_oe_o == 32'h0)
      else $error("data bus still driven after cycle end");
   AST_OE_ON: assert property ((act && !bus16_i)[*5] |->
      data_oe_o == 32'hffffffff)
      else $error("data bus not driven in 32-bit read");
   AST_OE_16: assert property ((act && bus16_i)[*5] |->
      data_oe_o == 32'h0000ffff)
      else $error("wrong lanes driven in 16-bit read");
   AST_POP_ONE: assert property ($onehot0({rx_data_pop_o,
      rx_sts_pop_o, tx_sts_pop_o}))
      else $error("two FIFOs popped at once");
   AST_POP_PULSE: assert property (rx_data_pop_o |=> !rx_data_pop_o)
      else $error("RX data pop longer than one cycle");
   AST_POP_CAUSE: assert property (rx_data_pop_o |->
      $past(data_oe_o) != 32'h0)
      else $error("RX data pop without a read");
   // Four stable cycles cover singles and each burst beat
   AST_DIRECT: assert property ((act && fifo_sel_i && !bus16_i &&
      $stable(addr_i))[*4] |-> data_o == rx_data_i)
      else $error("direct read not from RX data FIFO");
   AST_PROBE: assert property ((act && !fifo_sel_i && !bus16_i &&
      addr_i == host_read_pkg::PROBE_OFF[7:1])[*5] |->
      data_o == host_read_pkg::PROBE_VALUE)
      else $error("probe register value wrong");
   AST_CLR: assert property (rx_drop_clr_o |-> !fifo_sel_i &&
      addr_i == host_read_pkg::RX_DROP_OFF[7:1])
      else $error("counter clear without counter read");
   AST_OVER_CLR: assert property ((!act)[*4] |=> !burst_over_o)
      else $error("burst length flag stuck in idle");
   // Main scenarios reached
   cover property (rx_data_pop_o && fifo_sel_i);
   cover property (burst_over_o);
   cover property (rx_drop_clr_o);
   cover property (act && bus16_i);
   cover property (burst_over_o && bus16_i);
endmodule : host_read_port_asserts
bind host_read_port host_read_port_asserts #(.BURST_32(BURST_32),
   .BURST_16(BURST_16)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .chip_select_low_i(chip_select_low_i),
   .read_strobe_low_i(read_strobe_low_i), .fifo_sel_i(fifo_sel_i),
   .addr_i(addr_i), .bus16_i(bus16_i), .rx_data_i(rx_data_i),
   .data_o(data_o), .data_oe_o(data_oe_o), .rx_data_pop_o(rx_data_pop_o),
   .rx_sts_pop_o(rx_sts_pop_o), .tx_sts_pop_o(tx_sts_pop_o),
   .rx_drop_clr_o(rx_drop_clr_o), .burst_over_o(burst_over_o));
`default_nettype wire

// *** tb/host_model.sv ***
// Host processor model driving strobes, address and FIFO select
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input  wire logic       clk_i,
   output logic            chip_select_low_o,
   output logic            read_strobe_low_o,
   output logic            fifo_sel_o,
   output logic [7:1]      addr_o,
   output logic            bus16_o
);
   logic turn;  // Picks which strobe is released first
   initial begin
      chip_select_low_o = 1'b1;
      read_strobe_low_o = 1'b1;
      fifo_sel_o = 1'b0;
      addr_o = 7'h00;
      bus16_o = 1'b0;
      turn = 1'b0;
   end
   // Address and select set up with the strobes, held to the end
   task automatic open_cyc(input logic s, input logic [7:0] o,
                           input logic w);
      @(negedge clk_i);
      fifo_sel_o = s;
      addr_o = o[7:1];
      bus16_o = w;
      chip_select_low_o = 1'b0;
      read_strobe_low_o = 1'b0;
   endtask : open_cyc
   // New burst address, held at least the address cycle time
   task automatic move(input logic [7:0] o);
      @(negedge clk_i);
      addr_o = o[7:1];
   endtask : move
   // Release strobes in alternating order, then idle 500 ns
   task automatic close_cyc();
      @(negedge clk_i);
      if (turn) begin
         read_strobe_low_o = 1'b1;
      end else begin
         chip_select_low_o = 1'b1;
      end
      turn = !turn;
      @(negedge clk_i);
      chip_select_low_o = 1'b1;
      read_strobe_low_o = 1'b1;
      repeat (5) @(negedge clk_i);
   endtask : close_cyc
endmodule : host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the host read port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        clk_i, rst_i, cs_low, rd_low, fsel, b16, clr, over;
   logic [7:1]  addr;
   logic [31:0] rx_d, rx_s, tx_s, rinf, tinf, dpc, drop, data, oe;
   logic        pop_d, pop_s, pop_t;
   int          mismatches, check_count, seed, i;
   int          pops[4], want[4];  // Pops seen and expected per source
   logic [7:0]  offs[9], q[$];      // Single offsets, 16-bit burst list
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = !clk_i;
   end
   host_model host_u (.clk_i(clk_i), .chip_select_low_o(cs_low),
      .read_strobe_low_o(rd_low), .fifo_sel_o(fsel), .addr_o(addr),
      .bus16_o(b16));
   host_read_port dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .chip_select_low_i(cs_low), .read_strobe_low_i(rd_low),
      .fifo_sel_i(fsel), .addr_i(addr), .bus16_i(b16), .rx_data_i(rx_d),
      .rx_sts_i(rx_s), .tx_sts_i(tx_s), .rx_fifo_fill_info_i(rinf),
      .tx_fifo_fill_info_i(tinf), .rx_datapath_control_i(dpc),
      .rx_drop_i(drop), .data_o(data), .data_oe_o(oe),
      .rx_data_pop_o(pop_d), .rx_sts_pop_o(pop_s), .tx_sts_pop_o(pop_t),
      .rx_drop_clr_o(clr), .burst_over_o(over));
   // FIFO heads advance on each pop; counts kept for the model
   always @(negedge clk_i) begin
      if (pop_d === 1'b1) begin
         rx_d <= $random(seed);
         pops[0]++;
      end
      if (pop_s === 1'b1) begin
         rx_s <= $random(seed);
         pops[1]++;
      end
      if (pop_t === 1'b1) begin
         tx_s <= $random(seed);
         pops[2]++;
      end
      if (clr === 1'b1) pops[3]++;
   end
   // ----------------------------------------------------------------
   // Model and checks
   // ----------------------------------------------------------------
   function automatic logic [31:0] expw(input logic s, input logic [7:0] o);
      if (s) return rx_d;
      case ({o[7:2], 2'b00})
         host_read_pkg::RX_DATA_OFF: return rx_d;
         host_read_pkg::RX_STS_OFF:  return rx_s;
         host_read_pkg::TX_STS_OFF:  return tx_s;
         host_read_pkg::PROBE_OFF:   return host_read_pkg::PROBE_VALUE;
         host_read_pkg::RX_DP_OFF:   return dpc;
         host_read_pkg::RX_INF_OFF:  return rinf;
         host_read_pkg::TX_INF_OFF:  return tinf;
         host_read_pkg::RX_DROP_OFF: return drop;
         default: return host_read_pkg::UNMAPPED_VALUE;
      endcase
   endfunction : expw
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         mismatches++;
      end
   endtask : chk
   // Data, lanes and burst flag of the beat now on the bus
   task automatic beat(input logic s, input logic [7:0] o, input logic w,
                       input logic ov);
      logic [31:0] e;
      e = expw(s, o);
      if (w) e = {16'h0, o[1] ? e[31:16] : e[15:0]};
      chk("data", e, w ? {16'h0, data[15:0]} : data);
      chk("lanes", w ? 32'h0000ffff : 32'hffffffff, oe);
      chk("burst_over", {31'h0, ov}, {31'h0, over});
      if (!w || o[1]) begin
         if (s || o[7:2] == 6'h00) want[0]++;
         else if (o[7:2] == 6'h10) want[1]++;
         else if (o[7:2] == 6'h12) want[2]++;
      end
      if (!s && o[7:2] == 6'h28) want[3]++;
   endtask : beat
   // Single or burst read; addresses come from the list
   task automatic rd(input logic s, input logic [7:0] o[$], input logic w);
      host_u.open_cyc(s, o[0], w);
      foreach (o[k]) begin
         if (k > 0) host_u.move(o[k]);
         repeat (4) @(negedge clk_i);
         beat(s, o[k], w, !s && k >= (w ? host_read_pkg::BURST_MAX_16 :
              host_read_pkg::BURST_MAX_32));
      end
      host_u.close_cyc();
      for (int j = 0; j < 4; j++) chk("pops", want[j], pops[j]);
   endtask : rd
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h96d3;
      {rx_d, rx_s, tx_s, rinf} = {$random(seed), $random(seed),
         $random(seed), $random(seed)};
      {tinf, dpc, drop} = {$random(seed), $random(seed), $random(seed)};
      rst_i = 1'b1;
      offs = '{host_read_pkg::RX_DATA_OFF, host_read_pkg::RX_STS_OFF,
         host_read_pkg::TX_STS_OFF, host_read_pkg::PROBE_OFF,
         host_read_pkg::RX_DP_OFF, host_read_pkg::RX_INF_OFF,
         host_read_pkg::TX_INF_OFF, host_read_pkg::RX_DROP_OFF, 8'h24};
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      foreach (offs[k]) begin
         rd(1'b0, '{offs[k]}, 1'b0);
      end
      for (i = 0; i < 4; i++) begin
         rd(1'b0, '{{5'h00, i[1:0], 1'b0}}, 1'b1);
      end
      rd(1'b0, '{8'h66}, 1'b1);
      for (i = 0; i < 6; i++) begin
         rd(1'b1, '{8'($random(seed)) & 8'hf8 | {6'h00, i[0], 1'b0}},
            i[1]);
      end
      rd(1'b0, '{8'h64, 8'h78, 8'h64, 8'h78, 8'h64, 8'h78, 8'h64, 8'h78,
         8'h64, 8'h78}, 1'b0);
      // Halfword burst one beat past its limit
      for (i = 0; i < 17; i++) begin
         q.push_back(i[0] ? 8'h7a : 8'h66);
      end
      rd(1'b0, q, 1'b1);
      rd(1'b1, '{8'h08, 8'hf0, 8'h38, 8'h80, 8'hc8, 8'h10, 8'h58, 8'ha0,
         8'he8, 8'h20}, 1'b0);
      stop_test();
   end
   // Cuts a hang short well beyond the expected run time
   initial begin
      #2000000;
      mismatches++;
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
